// File: core/rscs_pkg.sv
// shared constants and types of the reset strap configuration loader
package rscs_pkg;
  localparam int unsigned NPIN = 16;
  localparam int unsigned OTP_AW = 14;
  localparam int unsigned SEL_W = 16;
  localparam int unsigned PIN_PROTO = 9;
  localparam int unsigned DEF_SEL_PINS = 4;
  localparam logic [OTP_AW-1:0] INFO_BASE = 14'h0000;
  localparam logic [OTP_AW-1:0] CFG_BASE = 14'h0010;
  localparam logic [1:0] INFO_WORDS = 2'h3;
  localparam logic [4:0] MAX_CFG = 5'h10;
  localparam int unsigned HDR_PRESENT = 15;
  localparam int unsigned HDR_INVALID = 14;
  localparam int unsigned HDR_TYPE_LO = 12;
  localparam logic [1:0] BLK_CONFIG = 2'h0;
  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_SEL = 2'h1;
  localparam logic [1:0] ROLE_EEDIS = 2'h2;
  localparam logic [1:0] ROLE_A2 = 2'h3;
  localparam logic [15:0] SERCFG_ADDR = 16'h0000;
  localparam int unsigned SERCFG_I2C = 0;
  localparam int unsigned SERCFG_A2 = 1;

  typedef struct packed {
    logic i2c;
    logic a2;
    logic ee_dis;
    logic [SEL_W-1:0] sel;
  } rscs_strap_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } rscs_regwr_s;

  typedef enum logic [9:0] {
    ST_CAP   = 10'h001,
    ST_INFO  = 10'h002,
    ST_DEFLT = 10'h004,
    ST_PORTW = 10'h008,
    ST_HDR   = 10'h010,
    ST_LEN   = 10'h020,
    ST_SUM   = 10'h040,
    ST_CHK   = 10'h080,
    ST_APPLY = 10'h100,
    ST_DONE  = 10'h200
  } rscs_state_e;
endpackage

// File: core/rscs_strap_decode.sv
// strap role decode from latched pins and factory pin roles
`timescale 1ns/1ps
module rscs_strap_decode (
  input wire logic [rscs_pkg::NPIN-1:0] pins,
  input wire logic [2*rscs_pkg::NPIN-1:0] roles,
  input wire logic info_ok,
  output rscs_pkg::rscs_strap_s strap
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] role_of(input logic [2*rscs_pkg::NPIN-1:0] r, input int unsigned i,
                                         input logic ok);
    role_of = ok ? r[2*i+:2] : rscs_pkg::ROLE_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4:0] n;
    n = 5'h00;
    strap = '0;
    for (int unsigned i = 0; i < rscs_pkg::NPIN; i++) begin
      case (role_of(roles, i, info_ok))
        rscs_pkg::ROLE_SEL: begin
          strap.sel[n[3:0]] = pins[i];
          n = n + 5'h01;
        end
        rscs_pkg::ROLE_EEDIS: begin
          strap.ee_dis = strap.ee_dis | pins[i];
        end
        rscs_pkg::ROLE_A2: begin
          strap.a2 = pins[i];
        end
        default: begin
        end
      endcase
    end
    if (n == 5'h00) begin
      strap.sel = {{(rscs_pkg::SEL_W-rscs_pkg::DEF_SEL_PINS){1'b0}}, pins[rscs_pkg::DEF_SEL_PINS-1:0]};
    end
    strap.i2c = pins[rscs_pkg::PIN_PROTO];
    if (!strap.i2c) begin
      strap.a2 = 1'b0;
    end
  end
endmodule

// File: core/rscs_cksum.sv
// running 16-bit checksum of stored block words
`timescale 1ns/1ps
module rscs_cksum (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic add,
  input wire logic [15:0] din,
  output logic zero
);
  logic [15:0] sum_q;
  logic [15:0] sum_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sum_d = sum_q;
    if (load) begin
      sum_d = din;
    end else if (add) begin
      sum_d = sum_q + din;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sum_q <= 16'h0000;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign zero = (sum_q == 16'h0000);
endmodule

// File: core/rscs_loader.sv
// start-up strap capture and stored configuration loader
`timescale 1ns/1ps
// Functional notes
// - protocol strap low SPI, high I2C
// - latch straps at reset release
// - undriven strap pins read as one
// - pin roles come from factory info
// - no address strap gives A2 zero
// - several address straps: highest index wins
// - address strap ignored under SPI
// - high disable strap blocks EEPROM reads
// - no disable strap: search for EEPROM
// - several disable straps are ORed
// - no select pins: use pins 3..0
// - pulled-high default pins select image 15
// - select bits in pin index order
// - zero-extend short select, widen long one
// - unprogrammed part: default strap behaviour
// - strap values stay overwritable later
// - defaults first, then stored image applied
// - factory info block always loaded
// - defaults: outputs off, pins inputs
// - write-once store, 2 to 16 images
// - skip blocks marked invalid
// - bad checksum: image not applied
// - no EEPROM search under SPI
module rscs_loader (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [rscs_pkg::NPIN-1:0] gpio_in,
  input wire logic [rscs_pkg::NPIN-1:0] gpio_driven,
  output logic otp_rd,
  output logic [rscs_pkg::OTP_AW-1:0] otp_addr,
  input wire logic [15:0] otp_rdata,
  input wire logic otp_rvalid,
  output logic reg_default,
  output logic reg_wr,
  output rscs_pkg::rscs_regwr_s reg_wr_data,
  output rscs_pkg::rscs_strap_s strap,
  output logic eeprom_search,
  output logic host_port_en,
  output logic load_done,
  output logic cfg_loaded,
  output logic cfg_err
);
  ////////////////////////////////////////////////////////////////////////////
  rscs_pkg::rscs_state_e state_q;
  rscs_pkg::rscs_state_e state_d;
  logic [rscs_pkg::NPIN-1:0] pins_q;
  logic [rscs_pkg::NPIN-1:0] pins_d;
  logic [2*rscs_pkg::NPIN-1:0] roles_q;
  logic [2*rscs_pkg::NPIN-1:0] roles_d;
  logic info_ok_q;
  logic info_ok_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  rscs_pkg::rscs_strap_s strap_q;
  rscs_pkg::rscs_strap_s strap_d;
  rscs_pkg::rscs_strap_s strap_dec;
  logic [rscs_pkg::OTP_AW-1:0] addr_q;
  logic [rscs_pkg::OTP_AW-1:0] addr_d;
  logic [rscs_pkg::OTP_AW-1:0] body_q;
  logic [rscs_pkg::OTP_AW-1:0] body_d;
  logic [rscs_pkg::OTP_AW-1:0] len_q;
  logic [rscs_pkg::OTP_AW-1:0] len_d;
  logic [rscs_pkg::OTP_AW-1:0] left_q;
  logic [rscs_pkg::OTP_AW-1:0] left_d;
  logic [15:0] hdr_q;
  logic [15:0] hdr_d;
  logic [15:0] ra_q;
  logic [15:0] ra_d;
  logic phase_q;
  logic phase_d;
  logic [4:0] blk_q;
  logic [4:0] blk_d;
  logic pend_q;
  logic pend_d;
  logic got;
  logic ck_load;
  logic ck_add;
  logic ck_zero;
  logic otp_rd_q;
  logic otp_rd_d;
  logic [rscs_pkg::OTP_AW-1:0] otp_addr_q;
  logic [rscs_pkg::OTP_AW-1:0] otp_addr_d;
  logic def_q;
  logic def_d;
  logic wr_q;
  logic wr_d;
  rscs_pkg::rscs_regwr_s wr_data_q;
  rscs_pkg::rscs_regwr_s wr_data_d;
  logic ee_q;
  logic ee_d;
  logic done_q;
  logic done_d;
  logic loaded_q;
  logic loaded_d;
  logic err_q;
  logic err_d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_wanted(input logic [15:0] h, input logic [rscs_pkg::SEL_W-1:0] sel);
    is_wanted = !h[rscs_pkg::HDR_INVALID] && (h[rscs_pkg::HDR_TYPE_LO+:2] == rscs_pkg::BLK_CONFIG)
                && ({{(rscs_pkg::SEL_W-8){1'b0}}, h[7:0]} == sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  rscs_strap_decode u_dec (
    .pins(pins_q),
    .roles(roles_q),
    .info_ok(info_ok_q),
    .strap(strap_dec)
  );

  rscs_cksum u_ck (
    .clk(clk),
    .resetn(resetn),
    .load(ck_load),
    .add(ck_add),
    .din(otp_rdata),
    .zero(ck_zero)
  );

  assign got = pend_q && otp_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    roles_d = roles_q;
    info_ok_d = info_ok_q;
    idx_d = idx_q;
    strap_d = strap_q;
    addr_d = addr_q;
    body_d = body_q;
    len_d = len_q;
    left_d = left_q;
    hdr_d = hdr_q;
    ra_d = ra_q;
    phase_d = phase_q;
    blk_d = blk_q;
    pend_d = pend_q;
    otp_rd_d = 1'b0;
    otp_addr_d = otp_addr_q;
    def_d = 1'b0;
    wr_d = 1'b0;
    wr_data_d = wr_data_q;
    ee_d = ee_q;
    done_d = done_q;
    loaded_d = loaded_q;
    err_d = err_q;
    ck_load = 1'b0;
    ck_add = 1'b0;
    if (got) begin
      pend_d = 1'b0;
    end
    if ((state_q == rscs_pkg::ST_INFO || state_q == rscs_pkg::ST_HDR || state_q == rscs_pkg::ST_LEN
         || state_q == rscs_pkg::ST_SUM || state_q == rscs_pkg::ST_APPLY) && !pend_q) begin
      otp_rd_d = 1'b1;
      otp_addr_d = addr_q;
      pend_d = 1'b1;
    end
    case (state_q)
      rscs_pkg::ST_CAP: begin
        pins_d = gpio_in | ~gpio_driven;
        addr_d = rscs_pkg::INFO_BASE;
        idx_d = 2'h0;
        state_d = rscs_pkg::ST_INFO;
      end
      rscs_pkg::ST_INFO: begin
        if (got) begin
          case (idx_q)
            2'h0: info_ok_d = otp_rdata[rscs_pkg::HDR_PRESENT] && !otp_rdata[rscs_pkg::HDR_INVALID];
            2'h1: roles_d[15:0] = otp_rdata;
            default: roles_d[31:16] = otp_rdata;
          endcase
          addr_d = addr_q + 14'h0001;
          idx_d = idx_q + 2'h1;
          if (idx_q == rscs_pkg::INFO_WORDS - 2'h1) begin
            state_d = rscs_pkg::ST_DEFLT;
          end
        end
      end
      rscs_pkg::ST_DEFLT: begin
        def_d = 1'b1;
        strap_d = strap_dec;
        ee_d = strap_dec.i2c && !strap_dec.ee_dis;
        state_d = rscs_pkg::ST_PORTW;
      end
      rscs_pkg::ST_PORTW: begin
        wr_d = 1'b1;
        wr_data_d.addr = rscs_pkg::SERCFG_ADDR;
        wr_data_d.data = 16'h0000;
        wr_data_d.data[rscs_pkg::SERCFG_I2C] = strap_q.i2c;
        wr_data_d.data[rscs_pkg::SERCFG_A2] = strap_q.a2;
        addr_d = rscs_pkg::CFG_BASE;
        blk_d = 5'h00;
        state_d = rscs_pkg::ST_HDR;
      end
      rscs_pkg::ST_HDR: begin
        if (got) begin
          if (!otp_rdata[rscs_pkg::HDR_PRESENT] || blk_q == rscs_pkg::MAX_CFG) begin
            err_d = 1'b1;
            state_d = rscs_pkg::ST_DONE;
          end else begin
            hdr_d = otp_rdata;
            ck_load = 1'b1;
            addr_d = addr_q + 14'h0001;
            state_d = rscs_pkg::ST_LEN;
          end
        end
      end
      rscs_pkg::ST_LEN: begin
        if (got) begin
          ck_add = 1'b1;
          len_d = otp_rdata[rscs_pkg::OTP_AW-1:0];
          left_d = {otp_rdata[rscs_pkg::OTP_AW-2:0], 1'b1};
          body_d = addr_q + 14'h0001;
          if (hdr_q[rscs_pkg::HDR_TYPE_LO+:2] == rscs_pkg::BLK_CONFIG && !hdr_q[rscs_pkg::HDR_INVALID]) begin
            blk_d = blk_q + 5'h01;
          end
          if (is_wanted(hdr_q, strap_q.sel)) begin
            addr_d = addr_q + 14'h0001;
            state_d = rscs_pkg::ST_SUM;
          end else begin
            addr_d = addr_q + 14'h0002 + {otp_rdata[rscs_pkg::OTP_AW-2:0], 1'b0};
            state_d = rscs_pkg::ST_HDR;
          end
        end
      end
      rscs_pkg::ST_SUM: begin
        if (got) begin
          ck_add = 1'b1;
          addr_d = addr_q + 14'h0001;
          left_d = left_q - 14'h0001;
          if (left_q == 14'h0001) begin
            state_d = rscs_pkg::ST_CHK;
          end
        end
      end
      rscs_pkg::ST_CHK: begin
        addr_d = body_q;
        left_d = {len_q[rscs_pkg::OTP_AW-2:0], 1'b0};
        phase_d = 1'b0;
        if (!ck_zero) begin
          err_d = 1'b1;
          state_d = rscs_pkg::ST_DONE;
        end else if (len_q == 14'h0000) begin
          loaded_d = 1'b1;
          state_d = rscs_pkg::ST_DONE;
        end else begin
          state_d = rscs_pkg::ST_APPLY;
        end
      end
      rscs_pkg::ST_APPLY: begin
        if (got) begin
          addr_d = addr_q + 14'h0001;
          left_d = left_q - 14'h0001;
          phase_d = !phase_q;
          if (!phase_q) begin
            ra_d = otp_rdata;
          end else begin
            wr_d = 1'b1;
            wr_data_d.addr = ra_q;
            wr_data_d.data = otp_rdata;
          end
          if (left_q == 14'h0001) begin
            loaded_d = 1'b1;
            state_d = rscs_pkg::ST_DONE;
          end
        end
      end
      rscs_pkg::ST_DONE: begin
        done_d = 1'b1;
      end
      default: begin
        state_d = rscs_pkg::ST_CAP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= rscs_pkg::ST_CAP;
      pins_q <= '1;
      roles_q <= '0;
      info_ok_q <= 1'b0;
      idx_q <= 2'h0;
      strap_q <= '0;
      addr_q <= '0;
      body_q <= '0;
      len_q <= '0;
      left_q <= '0;
      hdr_q <= 16'h0000;
      ra_q <= 16'h0000;
      phase_q <= 1'b0;
      blk_q <= 5'h00;
      pend_q <= 1'b0;
      otp_rd_q <= 1'b0;
      otp_addr_q <= '0;
      def_q <= 1'b0;
      wr_q <= 1'b0;
      wr_data_q <= '0;
      ee_q <= 1'b0;
      done_q <= 1'b0;
      loaded_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      roles_q <= roles_d;
      info_ok_q <= info_ok_d;
      idx_q <= idx_d;
      strap_q <= strap_d;
      addr_q <= addr_d;
      body_q <= body_d;
      len_q <= len_d;
      left_q <= left_d;
      hdr_q <= hdr_d;
      ra_q <= ra_d;
      phase_q <= phase_d;
      blk_q <= blk_d;
      pend_q <= pend_d;
      otp_rd_q <= otp_rd_d;
      otp_addr_q <= otp_addr_d;
      def_q <= def_d;
      wr_q <= wr_d;
      wr_data_q <= wr_data_d;
      ee_q <= ee_d;
      done_q <= done_d;
      loaded_q <= loaded_d;
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign otp_rd = otp_rd_q;
  assign otp_addr = otp_addr_q;
  assign reg_default = def_q;
  assign reg_wr = wr_q;
  assign reg_wr_data = wr_data_q;
  assign strap = strap_q;
  assign eeprom_search = ee_q;
  assign host_port_en = done_q;
  assign load_done = done_q;
  assign cfg_loaded = loaded_q;
  assign cfg_err = err_q;
endmodule

// File: verification/rscs_otp_model.sv
// behavioural stored-image memory answering the loader read port
`timescale 1ns/1ps
module rscs_otp_model (
  input wire logic clk,
  input wire logic otp_rd,
  input wire logic [rscs_pkg::OTP_AW-1:0] otp_addr,
  output logic [15:0] otp_rdata,
  output logic otp_rvalid
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  int lat;
  int cnt;
  initial begin
    otp_rvalid = 1'b0;
    otp_rdata = 16'h0000;
    last = 16'h0000;
    lat = 1;
    cnt = 0;
  end
  // one read outstanding, answer after lat cycles, data lines scrambled when idle
  always @(posedge clk) begin
    otp_rvalid <= 1'b0;
    otp_rdata <= ~last;
    if (otp_rd) begin
      cnt <= lat;
    end else if (cnt == 1) begin
      otp_rvalid <= 1'b1;
      otp_rdata <= mem[otp_addr[7:0]];
      last <= mem[otp_addr[7:0]];
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: verification/rscs_loader_checker.sv
// assertion checker of the strap configuration loader
`timescale 1ns/1ps
module rscs_loader_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic otp_rd,
  input wire logic reg_default,
  input wire logic reg_wr,
  input wire rscs_pkg::rscs_regwr_s reg_wr_data,
  input wire rscs_pkg::rscs_strap_s strap,
  input wire logic eeprom_search,
  input wire logic host_port_en,
  input wire logic load_done,
  input wire logic cfg_loaded,
  input wire logic cfg_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic def_q;
  logic def_d;
  always_comb def_d = def_q | reg_default;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) def_q <= 1'b0;
    else def_q <= def_d;
  end
  sequence s_sercfg;
    reg_wr && reg_wr_data.addr == rscs_pkg::SERCFG_ADDR && reg_wr_data.data[rscs_pkg::SERCFG_I2C] == strap.i2c;
  endsequence
  a_port_follows_done: assert property (host_port_en == load_done && (!host_port_en || cfg_loaded || cfg_err))
    else $error("host port enable differs");
  a_done_sticky: assert property (load_done |=> load_done) else $error("load done dropped");
  a_search_rule: assert property (load_done |-> eeprom_search == (strap.i2c && !strap.ee_dis))
    else $error("eeprom search wrong");
  a_default_first: assert property (reg_wr |-> def_q) else $error("write before defaults");
  a_default_once: assert property (reg_default |-> !def_q) else $error("defaults twice");
  a_sercfg_next: assert property (reg_default |-> ##[1:2] s_sercfg) else $error("serial config write missing");
  a_read_pulse: assert property (otp_rd |=> !otp_rd) else $error("read request too long");
  a_result_excl: assert property (!(cfg_loaded && cfg_err)) else $error("loaded and error together");
  a_quiet_done: assert property (load_done |-> !reg_wr && !otp_rd) else $error("activity after done");
  a_strap_hold: assert property (load_done |=> $stable(strap)) else $error("straps changed");
endmodule
bind rscs_loader rscs_loader_checker i_rscs_loader_checker (.clk(clk), .resetn(resetn), .otp_rd(otp_rd),
  .reg_default(reg_default), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .strap(strap),
  .eeprom_search(eeprom_search), .host_port_en(host_port_en), .load_done(load_done),
  .cfg_loaded(cfg_loaded), .cfg_err(cfg_err));

// File: verification/reset_strap_config_select_tb.sv
// self-checking bench of the strap configuration loader
`timescale 1ns/1ps
module reset_strap_config_select_tb;
  logic clk;
  logic resetn;
  logic [15:0] gpio_in;
  logic [15:0] gpio_driven;
  logic otp_rd, otp_rvalid, reg_default, reg_wr, eeprom_search, host_port_en, load_done, cfg_loaded, cfg_err;
  logic [rscs_pkg::OTP_AW-1:0] otp_addr;
  logic [15:0] otp_rdata;
  rscs_pkg::rscs_regwr_s reg_wr_data;
  rscs_pkg::rscs_strap_s strap;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h455E;
  logic [31:0] wq [$];
  rscs_loader i_rscs_loader (.clk(clk), .resetn(resetn), .gpio_in(gpio_in), .gpio_driven(gpio_driven),
    .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rdata(otp_rdata), .otp_rvalid(otp_rvalid),
    .reg_default(reg_default), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .strap(strap),
    .eeprom_search(eeprom_search), .host_port_en(host_port_en), .load_done(load_done),
    .cfg_loaded(cfg_loaded), .cfg_err(cfg_err));
  rscs_otp_model i_rscs_otp_model (.clk(clk), .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rdata(otp_rdata),
    .otp_rvalid(otp_rvalid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  always @(posedge clk) if (reg_wr === 1'b1) wq.push_back(reg_wr_data);
  ////////////////////////////////////////////////////////////////////////
  task automatic run(input int t, input logic [31:0] roles, input logic info, input int bad);
    logic [15:0] gi, gd, pins, sum, img;
    logic [15:0] w [$];
    logic [1:0] r;
    int sel, sn, a2, eed, p, n;
    rng = xs(rng);
    gi = rng[15:0];
    gd = (t == 0) ? 16'h0000 : rng[31:16];
    gd[9] = (t == 3);
    gi[9] = 1'b0;
    pins = (gi & gd) | ~gd;
    sel = 0;
    sn = 0;
    a2 = 0;
    eed = 0;
    for (int i = 0; i < 16; i++) begin
      r = info ? roles[2*i+:2] : 2'h0;
      if (r == rscs_pkg::ROLE_SEL) begin
        sel = sel | (pins[i] << sn);
        sn++;
      end
      if (r == rscs_pkg::ROLE_EEDIS) eed = eed | pins[i];
      if (r == rscs_pkg::ROLE_A2) a2 = pins[i];
    end
    if (sn == 0) sel = pins[3:0];
    img = sel[15:0] ^ ((bad == 2) ? 16'h0080 : 16'h0000);
    @(posedge clk);
    resetn <= 1'b0;
    gpio_in <= gi;
    gpio_driven <= gd;
    wq.delete();
    i_rscs_otp_model.lat = (t % 2) ? 3 : 1;
    for (int k = 0; k < 256; k++) i_rscs_otp_model.mem[k] = 16'h0000;
    i_rscs_otp_model.mem[0] = info ? 16'h8000 : 16'h0000;
    i_rscs_otp_model.mem[1] = roles[15:0];
    i_rscs_otp_model.mem[2] = roles[31:16];
    p = 16;
    for (int b = 0; b < 2; b++) begin
      sum = 16'h0000;
      w = {(b == 1) ? (16'h8000 | img) : (((t == 4) ? 16'h9000 : 16'hC000) | img), 16'h0002, 16'h0100,
        rng[15:0], 16'h0101 + t[15:0], ~rng[15:0]};
      foreach (w[k]) begin
        i_rscs_otp_model.mem[p] = w[k];
        sum = sum + w[k];
        p++;
      end
      i_rscs_otp_model.mem[p] = 16'h0000 - sum + ((bad == 1 && b == 1) ? 16'h0001 : 16'h0000);
      p++;
    end
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    if (t == 5) begin
      repeat (25) @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      wq.delete();
    end
    n = 0;
    while (load_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("i2c", strap.i2c, pins[9]);
    chk("sel", strap.sel, sel);
    chk("ee_dis", strap.ee_dis, eed);
    chk("a2", strap.a2, pins[9] ? a2 : 0);
    chk("search", eeprom_search, pins[9] & ~eed);
    chk("host_port", host_port_en, 1);
    chk("loaded", cfg_loaded, bad == 0);
    chk("err", cfg_err, bad != 0);
    chk("writes", wq.size(), (bad != 0) ? 1 : 3);
    chk("sercfg", wq[0], {rscs_pkg::SERCFG_ADDR, 14'h0000, a2[0] & pins[9], pins[9]});
    if (bad == 0 && wq.size() == 3) begin
      chk("wr1", wq[1], {16'h0100, rng[15:0]});
      chk("wr2", wq[2], {16'h0101 + t[15:0], ~rng[15:0]});
    end
    $display("test %0d done", t);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    gpio_in = 16'h0000;
    gpio_driven = 16'h0000;
    run(0, 32'h0042E41C, 1'b0, 1'b0);
    run(1, 32'h0042E41C, 1'b1, 1'b0);
    run(2, 32'h0042E41C, 1'b1, 1'b1);
    run(3, 32'h0042E41C, 1'b1, 1'b0);
    run(4, 32'h01000145, 1'b1, 1'b0);
    run(5, 32'h01000145, 1'b1, 2);
    test_done();
  end
endmodule
